/* logic/bridge_vga_decode_and_ordering.sv */
// Purpose: VGA decode, posted write buffering and delayed transaction queue
// Assumes: Base/limit window hits come in from outside; requests single phase
// Notes:   Answers to a request appear one clock after the request cycle
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Posted write FIFO
// ------------------------------------------------------------------
module bridge_post_fifo #(
  parameter int WIDTH = 68,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             full;
  assign full     = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign empty    = (wrPtr == rdPtr);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr[AW-1:0]];
  always_ff @(posedge core_clk) begin
    if (inValid && !full) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule : bridge_post_fifo

module bridge_vga_decode_and_ordering #(
  parameter int FIFO_DEPTH = bridge_vga_pkg::FIFO_DEPTH,
  parameter int DT_DEPTH   = bridge_vga_pkg::DT_DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        vgaEnable,
  input  wire logic        snoopEnable,
  input  wire logic        priWindowHit,
  input  wire logic        priValid,
  input  wire logic [3:0]  priCmd,
  input  wire logic [31:0] priAddr,
  input  wire logic [3:0]  priBe,
  input  wire logic [31:0] priData,
  output logic             priClaim,
  output logic             priRetry,
  output logic             priDone,
  output logic      [31:0] priRdData,
  input  wire logic        secWindowHit,
  input  wire logic        secValid,
  input  wire logic [3:0]  secCmd,
  input  wire logic [31:0] secAddr,
  input  wire logic [3:0]  secBe,
  input  wire logic [31:0] secData,
  output logic             secClaim,
  output logic             secRetry,
  output logic             dnValid,
  input  wire logic        dnReady,
  output logic      [67:0] dnEntry,
  output logic             upValid,
  input  wire logic        upReady,
  output logic      [67:0] upEntry,
  output logic             dtReqValid,
  input  wire logic        dtReqReady,
  output logic      [3:0]  dtReqCmd,
  output logic      [31:0] dtReqAddr,
  output logic      [3:0]  dtReqBe,
  output logic      [31:0] dtReqData,
  output logic             dtReqSingle,
  input  wire logic        dtRespValid,
  input  wire logic [31:0] dtRespData
);
  localparam int IW = $clog2(DT_DEPTH);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic isMem(input logic [3:0] c);
    return c == bridge_vga_pkg::CMD_MEM_RD || c == bridge_vga_pkg::CMD_MEM_WR ||
           c == bridge_vga_pkg::CMD_MEM_RDM || c == bridge_vga_pkg::CMD_MEM_RDL ||
           c == bridge_vga_pkg::CMD_MEM_WI;
  endfunction : isMem
  function automatic logic isIo(input logic [3:0] c);
    return c == bridge_vga_pkg::CMD_IO_RD || c == bridge_vga_pkg::CMD_IO_WR;
  endfunction : isIo
  function automatic logic isPosted(input logic [3:0] c);
    return c == bridge_vga_pkg::CMD_MEM_WR || c == bridge_vga_pkg::CMD_MEM_WI;
  endfunction : isPosted
  function automatic logic isRead(input logic [3:0] c);
    return c == bridge_vga_pkg::CMD_IO_RD || c == bridge_vga_pkg::CMD_CFG_RD ||
           c == bridge_vga_pkg::CMD_MEM_RD || c == bridge_vga_pkg::CMD_MEM_RDM ||
           c == bridge_vga_pkg::CMD_MEM_RDL;
  endfunction : isRead
  // Upper limit is the frame buffer top, so C0000h never matches
  function automatic logic inFrame(input logic [31:0] a);
    return a >= bridge_vga_pkg::FB_LO && a <= bridge_vga_pkg::FB_HI;
  endfunction : inFrame
  function automatic logic inVgaIo(input logic [31:0] a);
    return a[31:16] == 16'h0000 &&
           ((a[9:0] >= bridge_vga_pkg::IO_A_LO && a[9:0] <= bridge_vga_pkg::IO_A_HI) ||
            (a[9:0] >= bridge_vga_pkg::IO_B_LO && a[9:0] <= bridge_vga_pkg::IO_B_HI));
  endfunction : inVgaIo
  function automatic logic inPalette(input logic [31:0] a);
    return a[31:16] == 16'h0000 && (a[9:0] == bridge_vga_pkg::PAL_MASK ||
           a[9:0] == bridge_vga_pkg::PAL_WADDR || a[9:0] == bridge_vga_pkg::PAL_DATA);
  endfunction : inPalette
  function automatic logic vgaHit(input logic en, input logic [3:0] c, input logic [31:0] a);
    return en && ((isMem(c) && inFrame(a)) || (isIo(c) && inVgaIo(a)));
  endfunction : vgaHit
  // ----------------------------------------------------------------
  // Primary-side decode
  // ----------------------------------------------------------------
  logic priVga;
  logic priSnoop;
  logic priHit;
  assign priVga   = vgaHit(vgaEnable, priCmd, priAddr);
  // Snoop only adds anything while VGA mode is off
  assign priSnoop = snoopEnable && !vgaEnable && priCmd == bridge_vga_pkg::CMD_IO_WR &&
                    inPalette(priAddr);
  assign priHit   = priValid && (priVga || priSnoop || priWindowHit);

  // ----------------------------------------------------------------
  // Posted write buffers, one per direction
  // ----------------------------------------------------------------
  logic dnInReady;
  logic dnEmpty;
  logic dnPush;
  logic upInReady;
  logic upPush;
  logic secHit;
  // Every posted write is its own entry: nothing combined, merged or collapsed
  assign dnPush = priHit && isPosted(priCmd) && dnInReady;
  bridge_post_fifo #(.WIDTH(bridge_vga_pkg::ENTRY_W), .DEPTH(FIFO_DEPTH)) dnFifo (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .inValid  (dnPush),
    .inReady  (dnInReady),
    .inData   ({priAddr, priBe, priData}),
    .outValid (dnValid),
    .outReady (dnReady),
    .outData  (dnEntry),
    .empty    (dnEmpty)
  );
  // Secondary initiator: VGA targets stay on the secondary bus
  assign secHit = secValid && !vgaHit(vgaEnable, secCmd, secAddr) && !secWindowHit;
  assign upPush = secHit && isPosted(secCmd) && upInReady;
  bridge_post_fifo #(.WIDTH(bridge_vga_pkg::ENTRY_W), .DEPTH(FIFO_DEPTH)) upFifo (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .inValid  (upPush),
    .inReady  (upInReady),
    .inData   ({secAddr, secBe, secData}),
    .outValid (upValid),
    .outReady (upReady),
    .outData  (upEntry),
    .empty    ()
  );

  // ----------------------------------------------------------------
  // Delayed transaction queue
  // ----------------------------------------------------------------
  bridge_vga_pkg::dt_state_t dtState [DT_DEPTH];
  logic [3:0]  dtCmd  [DT_DEPTH];
  logic [31:0] dtAddr [DT_DEPTH];
  logic [3:0]  dtBe   [DT_DEPTH];
  logic [31:0] dtData [DT_DEPTH];
  logic [DT_DEPTH-1:0] match;
  logic [DT_DEPTH-1:0] isFree;
  logic [DT_DEPTH-1:0] isWait;
  logic          hitAny;
  logic          hitDone;
  logic [IW-1:0] hitIdx;
  logic          freeAny;
  logic [IW-1:0] freeIdx;
  logic          waitAny;
  logic [IW-1:0] waitIdx;
  logic          priDelayed;
  logic          issueBusy;
  logic          issueStart;
  logic [IW-1:0] issueIdx;
  assign priDelayed = priHit && !isPosted(priCmd);
  for (genvar g = 0; g < DT_DEPTH; g++) begin : gEntry
    // A retried repeat must present the same command, address, enables and write data
    assign match[g]  = dtState[g] != bridge_vga_pkg::DT_FREE && dtCmd[g] == priCmd &&
                       dtAddr[g] == priAddr && dtBe[g] == priBe &&
                       (isRead(priCmd) || dtData[g] == priData);
    assign isFree[g] = dtState[g] == bridge_vga_pkg::DT_FREE;
    assign isWait[g] = dtState[g] == bridge_vga_pkg::DT_WAIT;
  end

  always_comb begin
    hitAny  = 1'b0;
    hitIdx  = '0;
    freeAny = 1'b0;
    freeIdx = '0;
    waitAny = 1'b0;
    waitIdx = '0;
    for (int i = DT_DEPTH - 1; i >= 0; i--) begin
      if (match[i]) begin
        hitAny = 1'b1;
        hitIdx = IW'(i);
      end
      if (isFree[i]) begin
        freeAny = 1'b1;
        freeIdx = IW'(i);
      end
      if (isWait[i]) begin
        waitAny = 1'b1;
        waitIdx = IW'(i);
      end
    end
  end
  assign hitDone = hitAny && dtState[hitIdx] == bridge_vga_pkg::DT_DONE;

  // Delayed requests must not pass posted writes heading the same way
  assign issueStart = !issueBusy && waitAny && dnEmpty;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DT_DEPTH; i++) begin
        dtState[i] <= bridge_vga_pkg::DT_FREE;
      end
    end else begin
      if (priDelayed && hitDone) begin
        dtState[hitIdx] <= bridge_vga_pkg::DT_FREE;
      end else if (priDelayed && !hitAny && freeAny) begin
        dtState[freeIdx] <= bridge_vga_pkg::DT_WAIT;
      end
      if (issueStart) begin
        dtState[waitIdx] <= bridge_vga_pkg::DT_BUSY;
      end
      if (issueBusy && !dtReqValid && dtRespValid) begin
        dtState[issueIdx] <= bridge_vga_pkg::DT_DONE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (priDelayed && !hitAny && freeAny) begin
      dtCmd[freeIdx]  <= priCmd;
      dtAddr[freeIdx] <= priAddr;
      dtBe[freeIdx]   <= priBe;
      dtData[freeIdx] <= priData;
    end else if (issueBusy && !dtReqValid && dtRespValid && isRead(dtCmd[issueIdx])) begin
      // Writes keep their data so the repeated request still matches
      dtData[issueIdx] <= dtRespData;
    end
  end

  // ----------------------------------------------------------------
  // Master side: one delayed request outstanding at a time
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      issueBusy   <= 1'b0;
      issueIdx    <= '0;
      dtReqValid  <= 1'b0;
      dtReqCmd    <= 4'h0;
      dtReqAddr   <= 32'h0000_0000;
      dtReqBe     <= 4'h0;
      dtReqData   <= 32'h0000_0000;
      dtReqSingle <= 1'b0;
    end else if (issueStart) begin
      issueBusy   <= 1'b1;
      issueIdx    <= waitIdx;
      dtReqValid  <= 1'b1;
      dtReqCmd    <= dtCmd[waitIdx];
      dtReqAddr   <= dtAddr[waitIdx];
      dtReqBe     <= dtBe[waitIdx];
      dtReqData   <= dtData[waitIdx];
      // Frame buffer reads may have side effects: no prefetch
      dtReqSingle <= isRead(dtCmd[waitIdx]) &&
                     (!isMem(dtCmd[waitIdx]) || inFrame(dtAddr[waitIdx]) ||
                      dtCmd[waitIdx] == bridge_vga_pkg::CMD_MEM_RD);
    end else if (dtReqValid && dtReqReady) begin
      dtReqValid <= 1'b0;
    end else if (issueBusy && !dtReqValid && dtRespValid) begin
      issueBusy <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Answers to initiators, one clock after the request
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      priClaim  <= 1'b0;
      priRetry  <= 1'b0;
      priDone   <= 1'b0;
      priRdData <= 32'h0000_0000;
      secClaim  <= 1'b0;
      secRetry  <= 1'b0;
    end else begin
      priClaim <= priHit;
      priDone  <= dnPush || (priDelayed && hitDone);
      priRetry <= (priHit && isPosted(priCmd) && !dnInReady) ||
                  (priDelayed && !hitDone);
      if (priDelayed && hitDone) begin
        priRdData <= dtData[hitIdx];
      end
      secClaim <= secHit;
      // Upstream delayed traffic is not queued here; it is retried
      secRetry <= secHit && !upPush;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_fb_request;
    priValid && vgaEnable && isMem(priCmd) && priAddr >= 32'h000a_0000 && priAddr <= 32'h000b_ffff;
  endsequence

  a_vga_fb_claim: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_fb_request |=> priClaim)
    else $error("VGA frame buffer access not claimed");
  a_bios_not_vga: assert property (@(posedge core_clk) disable iff (sys_rst)
    priValid && !priWindowHit && priAddr[31:16] == 16'h000c && isMem(priCmd) |=> !priClaim)
    else $error("BIOS region claimed through VGA decode");
  a_sec_vga_ignored: assert property (@(posedge core_clk) disable iff (sys_rst)
    secValid && vgaEnable && isIo(secCmd) && secAddr[31:16] == 16'h0000 &&
    secAddr[9:0] == 10'h3c0 |=> !secClaim)
    else $error("Secondary VGA access claimed");
  a_io_alias_claim: assert property (@(posedge core_clk) disable iff (sys_rst)
    priValid && vgaEnable && isIo(priCmd) && priAddr[31:16] == 16'h0000 &&
    priAddr[9:0] == 10'h3bb |=> priClaim)
    else $error("Aliased VGA I/O address not claimed");
  a_snoop_pal_claim: assert property (@(posedge core_clk) disable iff (sys_rst)
    priValid && snoopEnable && priCmd == 4'h3 && priAddr[31:16] == 16'h0000 &&
    priAddr[9:0] == 10'h3c9 |=> priClaim)
    else $error("Palette write not claimed in snoop mode");
  a_snoop_read_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    priValid && snoopEnable && !vgaEnable && !priWindowHit && priCmd == 4'h2 |=> !priClaim)
    else $error("Palette read claimed in snoop mode");
  a_delayed_retry: assert property (@(posedge core_clk) disable iff (sys_rst)
    priValid && priHit && isRead(priCmd) && !hitDone |=> priRetry && !priDone)
    else $error("New delayed read not retried");
  a_posted_accept: assert property (@(posedge core_clk) disable iff (sys_rst)
    priHit && isPosted(priCmd) && dnInReady |=> priDone && !priRetry)
    else $error("Posted write refused with room in buffer");
  a_posted_order: assert property (@(posedge core_clk) disable iff (sys_rst)
    dnValid && !dnReady |=> dnValid && $stable(dnEntry))
    else $error("Posted head changed while stalled");
  a_single_phase: assert property (@(posedge core_clk) disable iff (sys_rst)
    issueStart && isRead(dtCmd[waitIdx]) && inFrame(dtAddr[waitIdx]) |=> dtReqSingle)
    else $error("Frame buffer read issued as prefetch");
  a_completion_held: assert property (@(posedge core_clk) disable iff (sys_rst)
    issueBusy && !dtReqValid && dtRespValid |=> dtState[$past(issueIdx)] == bridge_vga_pkg::DT_DONE)
    else $error("Completion not stored");
endmodule : bridge_vga_decode_and_ordering
`default_nettype wire

/* logic/bridge_vga_pkg.sv */
// Purpose: Shared constants for the bridge forwarding-control block
// Assumes: Transaction-level request ports, one request per cycle
// Notes:   Command codes follow the public PCI command encoding
`default_nettype none
package bridge_vga_pkg;
  // ----------------------------------------------------------------
  // Bus commands
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_IO_RD   = 4'h2;
  localparam logic [3:0] CMD_IO_WR   = 4'h3;
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_CFG_RD  = 4'ha;
  localparam logic [3:0] CMD_CFG_WR  = 4'hb;
  localparam logic [3:0] CMD_MEM_RDM = 4'hc;
  localparam logic [3:0] CMD_MEM_RDL = 4'he;
  localparam logic [3:0] CMD_MEM_WI  = 4'hf;
  // ----------------------------------------------------------------
  // VGA decode
  // ----------------------------------------------------------------
  localparam logic [31:0] FB_LO      = 32'h000a_0000;
  localparam logic [31:0] FB_HI      = 32'h000b_ffff;
  localparam logic [9:0]  IO_A_LO    = 10'h3b0;
  localparam logic [9:0]  IO_A_HI    = 10'h3bb;
  localparam logic [9:0]  IO_B_LO    = 10'h3c0;
  localparam logic [9:0]  IO_B_HI    = 10'h3df;
  localparam logic [9:0]  PAL_MASK   = 10'h3c6;
  localparam logic [9:0]  PAL_WADDR  = 10'h3c8;
  localparam logic [9:0]  PAL_DATA   = 10'h3c9;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int DT_DEPTH   = 4;
  localparam int ENTRY_W    = 68;
  typedef enum logic [1:0] {
    DT_FREE = 2'b00,
    DT_WAIT = 2'b01,
    DT_BUSY = 2'b10,
    DT_DONE = 2'b11
  } dt_state_t;
endpackage : bridge_vga_pkg
`default_nettype wire

/* verif/far_target.sv */
// Purpose: Downstream target model for delayed requests
// Assumes: One request outstanding at a time
// Notes:   slow adds wait states before accept and before answer
`timescale 1ns/100ps
`default_nettype none
module far_target (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        dtReqValid,
  input  wire logic [31:0] dtReqAddr,
  output logic             dtReqReady,
  output logic             dtRespValid,
  output logic      [31:0] dtRespData
);
  logic        busy;
  logic [3:0]  waitCnt;
  logic [31:0] heldAddr;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dtReqReady  <= 1'b0;
      dtRespValid <= 1'b0;
      dtRespData  <= 32'h0;
      busy        <= 1'b0;
      waitCnt     <= 4'h0;
      heldAddr    <= 32'h0;
    end else begin
      dtReqReady  <= 1'b0;
      dtRespValid <= 1'b0;
      // Data toggles when idle so a stale value never reads as good
      dtRespData  <= ~dtRespData;
      waitCnt     <= waitCnt + 4'h1;
      if (!busy && !dtReqValid) begin
        waitCnt <= 4'h0;
      end
      if (!busy && dtReqValid && !dtReqReady && waitCnt >= (slow ? 4'h6 : 4'h0)) begin
        dtReqReady <= 1'b1;
        busy       <= 1'b1;
        heldAddr   <= dtReqAddr;
        waitCnt    <= 4'h0;
      end
      // At least two cycles after accept, so the request has dropped
      if (busy && waitCnt >= (slow ? 4'h8 : 4'h2)) begin
        dtRespValid <= 1'b1;
        dtRespData  <= heldAddr ^ 32'h5a5a_0f0f;
        busy        <= 1'b0;
        waitCnt     <= 4'h0;
      end
    end
  end
endmodule : far_target
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for the bridge forwarding control
// Assumes: far_target answers delayed requests downstream
// Notes:   Inputs move on the falling edge of core_clk
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        core_clk, sys_rst, vgaEnable, snoopEnable, priWindowHit, priValid, secWindowHit, secValid;
  logic        dnReady, upReady, slow, priClaim, priRetry, priDone, secClaim, secRetry, dnValid, upValid;
  logic        dtReqValid, dtReqReady, dtRespValid, dtReqSingle, lastSingle;
  logic [3:0]  priCmd, priBe, secCmd, secBe, dtReqCmd, dtReqBe, lastBe, lastCmd;
  logic [31:0] priAddr, priData, secAddr, secData, priRdData, dtReqAddr, dtReqData, dtRespData, lastData;
  logic [67:0] dnEntry, upEntry;
  logic [67:0] expDn[$];
  // {vga, snoop, 0, claim}, command, 0, address
  logic [43:0] tbl[24] = '{
    44'h9_3_0_0000_03b0, 44'h9_2_0_0000_03bb, 44'h9_3_0_0000_03c0, 44'h9_2_0_0000_03df,
    44'h9_3_0_0000_fbc0, 44'h8_2_0_0000_03af, 44'h8_3_0_0000_03bc, 44'h8_2_0_0000_03e0,
    44'h8_3_0_0001_03c0, 44'h9_2_0_0000_07c0, 44'h9_6_0_000a_0000, 44'h8_6_0_0009_fffc,
    44'h8_6_0_000c_0000, 44'h9_c_0_000b_fffc, 44'h5_3_0_0000_03c6, 44'h5_3_0_0000_03c8,
    44'h5_3_0_0000_03c9, 44'h4_3_0_0000_03c7, 44'h5_3_0_0000_43c6, 44'h4_3_0_0001_03c6,
    44'h4_2_0_0000_03c6, 44'hd_3_0_0000_03c7, 44'hd_2_0_0000_03c6, 44'h0_3_0_0000_03c0};
  int          errors = 0;
  int          nCompared = 0;

  bridge_vga_decode_and_ordering dut (
    .core_clk, .sys_rst, .vgaEnable, .snoopEnable, .priWindowHit, .priValid, .priCmd, .priAddr, .priBe,
    .priData, .priClaim, .priRetry, .priDone, .priRdData, .secWindowHit, .secValid, .secCmd, .secAddr,
    .secBe, .secData, .secClaim, .secRetry, .dnValid, .dnReady, .dnEntry, .upValid, .upReady, .upEntry,
    .dtReqValid, .dtReqReady, .dtReqCmd, .dtReqAddr, .dtReqBe, .dtReqData, .dtReqSingle, .dtRespValid,
    .dtRespData);
  far_target partner (.core_clk, .sys_rst, .slow, .dtReqValid, .dtReqAddr, .dtReqReady, .dtRespValid,
    .dtRespData);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (dtReqValid === 1'b1) begin
      lastBe     <= dtReqBe;
      lastSingle <= dtReqSingle;
      lastCmd    <= dtReqCmd;
      lastData   <= dtReqData;
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [67:0] seen, input logic [67:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (errors == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic pri(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge core_clk);
    priValid = 1'b1;
    {priCmd, priAddr, priBe, priData} = {c, a, b, d};
    @(negedge core_clk);
    priValid = 1'b0;
  endtask : pri
  task automatic sec(input logic [3:0] c, input logic [31:0] a, input logic [1:0] exp);
    @(negedge core_clk);
    secValid = 1'b1;
    {secCmd, secAddr, secBe, secData} = {c, a, 4'h3, ~a};
    @(negedge core_clk);
    secValid = 1'b0;
    check({secClaim, secRetry}, exp);
  endtask : sec
  // Repeats the same request until completion; reads return the target data
  task automatic delayed(input logic [3:0] c, input logic [31:0] a, input logic exp);
    for (int k = 0; k < 40; k++) begin
      pri(c, a, 4'h5, a);
      check(priClaim, exp);
      if (!exp || priDone === 1'b1) break;
      check(priRetry, 1'b1);
    end
    if (exp) check(priDone, 1'b1);
    if (exp && !c[0]) check(priRdData, a ^ 32'h5a5a_0f0f);
  endtask : delayed
  task automatic drain;
    @(negedge core_clk);
    dnReady = 1'b1;
    while (expDn.size() > 0) begin
      check(dnValid, 1'b1);
      check(dnEntry, expDn.pop_front());
      @(negedge core_clk);
    end
    dnReady = 1'b0;
    check(dnValid, 1'b0);
  endtask : drain
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fill;
    priWindowHit = 1'b1;
    for (int i = 0; i <= 17; i++) begin
      @(negedge core_clk);
      if (i > 0) check({priClaim, priDone, priRetry}, {1'b1, i <= 16, i == 17});
      priValid = (i < 17);
      priCmd = i[0] ? bridge_vga_pkg::CMD_MEM_WI : bridge_vga_pkg::CMD_MEM_WR;
      {priAddr, priBe, priData} = {32'h0010_0040, i[3:0], i};
      if (i < 16) expDn.push_back({32'h0010_0040, i[3:0], i});
    end
    drain;
    priWindowHit = 1'b0;
  endtask : t_fill
  task automatic t_decode;
    logic [43:0] e;
    for (int i = 0; i < 24; i++) begin
      e = tbl[i];
      {vgaEnable, snoopEnable} = e[43:42];
      delayed(e[39:36], e[31:0], e[40]);
      if (e[39:36] == 4'hc) check({lastBe, lastSingle}, 5'hb);
      if (e[40]) check({lastCmd, lastData}, {e[39:36], e[31:0]});
    end
    snoopEnable = 1'b0;
  endtask : t_decode
  task automatic t_concurrent;
    vgaEnable = 1'b1;
    @(negedge core_clk);
    {priValid, secValid} = 2'b11;
    {priCmd, priAddr, priBe, priData} = {bridge_vga_pkg::CMD_MEM_WR, 32'h000b_fff0, 4'hc, 32'h1234_5678};
    {secCmd, secAddr, secBe, secData} = {bridge_vga_pkg::CMD_MEM_WR, 32'h0030_0000, 4'h3, 32'hcafe_0001};
    expDn.push_back({32'h000b_fff0, 4'hc, 32'h1234_5678});
    @(negedge core_clk);
    {priValid, secValid} = 2'b00;
    check({priClaim, priDone, priRetry, secClaim, secRetry}, 5'h1a);
    check(upValid, 1'b1);
    check(upEntry, {32'h0030_0000, 4'h3, 32'hcafe_0001});
    upReady = 1'b1;
    @(negedge core_clk);
    upReady = 1'b0;
    check(upValid, 1'b0);
    drain;
    sec(bridge_vga_pkg::CMD_IO_WR, 32'h0000_1000, 2'b11);
    sec(bridge_vga_pkg::CMD_IO_RD, 32'h0000_03c0, 2'b00);
    sec(bridge_vga_pkg::CMD_MEM_WR, 32'h000a_0000, 2'b00);
    vgaEnable = 1'b0;
  endtask : t_concurrent
  task automatic t_pending;
    logic [1:0]  got;
    logic [31:0] a;
    {slow, priWindowHit, got} = 4'hc;
    pri(bridge_vga_pkg::CMD_IO_RD, 32'h0000_2000, 4'h5, 32'h0);
    check({priClaim, priRetry, priDone}, 3'b110);
    pri(bridge_vga_pkg::CMD_MEM_RD, 32'h0050_0010, 4'h5, 32'h0);
    check({priClaim, priRetry, priDone}, 3'b110);
    pri(bridge_vga_pkg::CMD_MEM_WR, 32'h0040_0000, 4'hf, 32'h77);
    check({priClaim, priRetry, priDone}, 3'b101);
    expDn.push_back({32'h0040_0000, 4'hf, 32'h77});
    drain;
    for (int k = 0; k < 60 && got != 2'b11; k++) begin
      if (got[k[0]]) continue;
      a = k[0] ? 32'h0050_0010 : 32'h0000_2000;
      pri(k[0] ? bridge_vga_pkg::CMD_MEM_RD : bridge_vga_pkg::CMD_IO_RD, a, 4'h5, 32'h0);
      if (priDone === 1'b1) begin
        got[k[0]] = 1'b1;
        check(priRdData, a ^ 32'h5a5a_0f0f);
      end
    end
    check(got, 2'b11);
    delayed(bridge_vga_pkg::CMD_CFG_WR, 32'h0000_0104, 1'b1);
    delayed(bridge_vga_pkg::CMD_CFG_RD, 32'h0000_0104, 1'b1);
    delayed(bridge_vga_pkg::CMD_MEM_RDL, 32'h0060_0000, 1'b1);
    check({lastCmd, lastSingle}, {bridge_vga_pkg::CMD_MEM_RDL, 1'b0});
    {slow, priWindowHit} = 2'b00;
  endtask : t_pending

  initial begin
    {sys_rst, vgaEnable, snoopEnable, priWindowHit, priValid, secWindowHit, secValid, dnReady} = 8'h80;
    {upReady, slow, priCmd, priBe, secCmd, secBe} = 18'h0;
    {priAddr, priData, secAddr, secData} = 128'h0;
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    check({dnValid, upValid, dtReqValid, priClaim, secClaim}, 5'h0);
    t_fill;
    t_decode;
    t_concurrent;
    t_pending;
    complete_run;
  end
  initial begin
    #80000;
    errors++;
    complete_run;
  end
endmodule : tb
`default_nettype wire
